/* File: core/tmev_pkg.sv */
package tmev_pkg;

    // ********************************************************************
    // Register addresses
    // ********************************************************************
    localparam logic [15:0] OFS_PORT1_DIR = 16'hFF21;
    localparam logic [15:0] OFS_PORT3_DIR = 16'hFF23;
    localparam logic [15:0] OFS_MODE = 16'hFF6B;
    localparam logic [15:0] OFS_CMP = 16'hFF6C;
    localparam logic [15:0] OFS_CLKSEL = 16'hFF6D;
    localparam logic [15:0] OFS_COUNT = 16'hFF6E;

    // ********************************************************************
    // Reset values and fixed bits
    // ********************************************************************
    localparam logic [7:0] PORT_DIR_RST = 8'hFF;
    localparam logic [7:0] PORT3_FIXED = 8'hF0;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [2:0] CLKSEL_RST = 3'h0;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hFF;
    localparam logic [7:0] READ_NONE = 8'h00;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int MODE_CE_BIT = 7;
    localparam int MODE_PWM_BIT = 6;
    localparam int MODE_LVS_BIT = 3;
    localparam int MODE_LVR_BIT = 2;
    localparam int MODE_ALV_BIT = 1;
    localparam int MODE_OE_BIT = 0;
    localparam int CLKSEL_W = 3;
    localparam int P1_TMR_BIT = 7;
    localparam int P3_TMR_BIT = 3;
    localparam int PRESC_W = 12;

    // ********************************************************************
    // Count clock sources
    // ********************************************************************
    localparam logic [2:0] SEL_EXT_FALL = 3'h0;
    localparam logic [2:0] SEL_EXT_RISE = 3'h1;
    localparam logic [2:0] SEL_DIV1 = 3'h2;
    localparam logic [2:0] SEL_DIV2 = 3'h3;
    localparam logic [2:0] SEL_DIV16 = 3'h4;
    localparam logic [2:0] SEL_DIV64 = 3'h5;
    localparam logic [2:0] SEL_DIV256 = 3'h6;

    typedef enum logic [1:0] {
        TMEV_CLEAR = 2'b01,
        TMEV_PWM = 2'b10
    } tmev_mode_t;

endpackage

/* File: core/tmev_clk_src.sv */
`timescale 1ns/1ps
module tmev_clk_src (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [tmev_pkg::CLKSEL_W-1:0] sel,
    input wire logic ext_pin,
    output logic tick
);
    import tmev_pkg::*;

    logic [PRESC_W-1:0] presc_r;
    logic [2:0] sync_r;
    logic lvl_r;
    logic lvl_d_r;

    // ********************************************************************
    // Prescaler and divided tick
    // ********************************************************************
    // The prescaler runs freely, so a start may land up to one count
    // clock early; this keeps the divider shared and cheap.
    function automatic logic div_tick(input logic [PRESC_W-1:0] p,
                                      input logic [CLKSEL_W-1:0] s);
        case (s)
            SEL_DIV1: div_tick = 1'b1;
            SEL_DIV2: div_tick = p[0];
            SEL_DIV16: div_tick = &p[3:0];
            SEL_DIV64: div_tick = &p[5:0];
            SEL_DIV256: div_tick = &p[7:0];
            default: div_tick = &p;
        endcase
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            presc_r <= '0;
        end else begin
            presc_r <= presc_r + 1'b1;
        end
    end

    // ********************************************************************
    // External count input
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_r <= 3'h0;
            lvl_r <= 1'b0;
            lvl_d_r <= 1'b0;
        end else begin
            sync_r <= {sync_r[1:0], ext_pin};
            if (sync_r[1] == sync_r[2]) begin
                lvl_r <= sync_r[2];
            end
            lvl_d_r <= lvl_r;
        end
    end

    always_comb begin
        tick = 1'b0;
        if (run) begin
            case (sel)
                SEL_EXT_FALL: tick = lvl_d_r & ~lvl_r;
                SEL_EXT_RISE: tick = lvl_r & ~lvl_d_r;
                default: tick = div_tick(presc_r, sel);
            endcase
        end
    end

    chk_ext_rise_tick: assert property (@(posedge clk) disable iff (!rst_n)
        sel == SEL_EXT_RISE && sync_r[2] && sync_r[1] && !lvl_r
        ##1 run && sel == SEL_EXT_RISE |-> tick)
        else $error("Rising edge gave no count tick.");

endmodule

/* File: core/tmev_port_dir.sv */
`timescale 1ns/1ps
module tmev_port_dir (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] p1_dir,
    output logic [7:0] p3_dir
);
    import tmev_pkg::*;

    logic [7:0] p1_dir_r;
    logic [3:0] p3_dir_r;

    // ********************************************************************
    // Direction registers
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p1_dir_r <= PORT_DIR_RST;
            p3_dir_r <= PORT_DIR_RST[3:0];
        end else if (wr_en && addr == OFS_PORT1_DIR) begin
            p1_dir_r <= wdata;
        end else if (wr_en && addr == OFS_PORT3_DIR) begin
            p3_dir_r <= wdata[3:0];
        end
    end

    assign p1_dir = p1_dir_r;
    assign p3_dir = PORT3_FIXED | {4'h0, p3_dir_r};

    chk_dir_reset: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> p1_dir == PORT_DIR_RST && p3_dir == PORT_DIR_RST)
        else $error("Direction registers not all ones after reset.");

endmodule

/* File: core/tmev_counter_top.sv */
`timescale 1ns/1ps
// How it works
// - Clear mode: match clears counter, raises interrupt.
// - Clock-select bits 0..2 choose count clock.
// - Interval mode repeats match interrupt each period.
// - Enable bit 1 starts, 0 stops counter.
// - Event mode counts chosen external edge.
// - Direction bit 0 output, 1 input; reset FFH.
// - Square mode toggles output flop each match.
// - Square frequency is 1/(2t(N+1)).
// - Level set/reset bits preset output flop.
// - Mode bit 6 selects PWM generation.
// - Mode bit 1 picks PWM active level.
// - Mode bit 0 enables the output.
// - PWM active from overflow until compare match.
// - Stopping in PWM forces inactive level.
// - PWM period 256 clocks, width N.
// - PWM compare takes effect at overflow.
// - Output disabled holds timer output low.
module tmev_counter_top #(
    parameter int PIN_SEL = 0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic port_latch,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic timer_output,
    output logic match_interrupt_request
);
    import tmev_pkg::*;

    // ********************************************************************
    // Declarations
    // ********************************************************************
    logic count_enable_r;
    tmev_mode_t mode_r;
    logic active_level_r;
    logic output_enable_r;
    logic [7:0] compare_value_r;
    logic [7:0] cmp_act_r;
    logic [CLKSEL_W-1:0] clksel_r;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] cmp_use;
    logic tick;
    logic match;
    logic ff_r;
    logic pwm_act_r;
    logic tout_r;
    logic irq_r;
    logic [7:0] rdata_r;
    logic [7:0] p1_dir;
    logic [7:0] p3_dir;
    logic dir_bit;
    logic wr_mode;
    logic is_pwm;

    initial begin
        if (PIN_SEL != 0 && PIN_SEL != 1) begin
            $error("PIN_SEL must be 0 or 1.");
        end
    end

    // ********************************************************************
    // Submodules
    // ********************************************************************
    tmev_clk_src u_clk_src (
        .clk(clk),
        .rst_n(rst_n),
        .run(count_enable_r),
        .sel(clksel_r),
        .ext_pin(pin_in),
        .tick(tick)
    );

    tmev_port_dir u_port_dir (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(reg_wr),
        .addr(reg_addr),
        .wdata(reg_wdata),
        .p1_dir(p1_dir),
        .p3_dir(p3_dir)
    );

    // ********************************************************************
    // Control registers
    // ********************************************************************
    assign wr_mode = reg_wr && reg_addr == OFS_MODE;
    assign is_pwm = mode_r == TMEV_PWM;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_enable_r <= 1'b0;
            mode_r <= TMEV_CLEAR;
            active_level_r <= 1'b0;
            output_enable_r <= 1'b0;
        end else if (wr_mode) begin
            count_enable_r <= reg_wdata[MODE_CE_BIT];
            mode_r <= reg_wdata[MODE_PWM_BIT] ? TMEV_PWM : TMEV_CLEAR;
            active_level_r <= reg_wdata[MODE_ALV_BIT];
            output_enable_r <= reg_wdata[MODE_OE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            compare_value_r <= CMP_RST;
            clksel_r <= CLKSEL_RST;
        end else if (reg_wr && reg_addr == OFS_CMP) begin
            compare_value_r <= reg_wdata;
        end else if (reg_wr && reg_addr == OFS_CLKSEL) begin
            clksel_r <= reg_wdata[CLKSEL_W-1:0];
        end
    end

    // In PWM the written compare waits in a buffer; loading it only at
    // the wrap keeps each period's width whole.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmp_act_r <= CMP_RST;
        end else if (!(is_pwm && count_enable_r)) begin
            cmp_act_r <= compare_value_r;
        end else if (tick && cnt_r == COUNT_TOP) begin
            cmp_act_r <= compare_value_r;
        end
    end

    // ********************************************************************
    // Counter
    // ********************************************************************
    assign cmp_use = is_pwm ? cmp_act_r : compare_value_r;
    assign match = cnt_r == cmp_use;

    always_comb begin
        case (mode_r)
            TMEV_CLEAR: cnt_nxt = match ? COUNT_RST : cnt_r + 8'h01;
            TMEV_PWM: cnt_nxt = cnt_r + 8'h01;
            default: cnt_nxt = COUNT_RST;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !count_enable_r) begin
            cnt_r <= COUNT_RST;
        end else if (tick) begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= count_enable_r && tick && !is_pwm && match;
        end
    end

    assign match_interrupt_request = irq_r;

    // ********************************************************************
    // Output flop and PWM level
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ff_r <= 1'b0;
        end else if (wr_mode && !reg_wdata[MODE_PWM_BIT]
                     && reg_wdata[MODE_LVS_BIT] != reg_wdata[MODE_LVR_BIT]) begin
            ff_r <= reg_wdata[MODE_LVS_BIT];
        end else if (count_enable_r && tick && !is_pwm && match
                     && active_level_r) begin
            ff_r <= ~ff_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !count_enable_r || !is_pwm) begin
            pwm_act_r <= 1'b0;
        end else if (tick && cnt_nxt == COUNT_RST) begin
            pwm_act_r <= compare_value_r != COUNT_RST;
        end else if (tick && cnt_nxt == cmp_act_r) begin
            pwm_act_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !output_enable_r) begin
            tout_r <= 1'b0;
        end else if (is_pwm) begin
            tout_r <= pwm_act_r ^ active_level_r;
        end else begin
            tout_r <= ff_r;
        end
    end

    assign timer_output = tout_r;

    // ********************************************************************
    // Shared pin and register read
    // ********************************************************************
    assign dir_bit = PIN_SEL == 0 ? p1_dir[P1_TMR_BIT] : p3_dir[P3_TMR_BIT];
    assign pin_oe = ~dir_bit;
    assign pin_out = pin_oe & (port_latch | tout_r);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= READ_NONE;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_PORT1_DIR: rdata_r <= p1_dir;
                OFS_PORT3_DIR: rdata_r <= p3_dir;
                OFS_MODE: rdata_r <= {count_enable_r, is_pwm, 4'h0,
                                      active_level_r, output_enable_r};
                OFS_CMP: rdata_r <= compare_value_r;
                OFS_CLKSEL: rdata_r <= {5'h00, clksel_r};
                OFS_COUNT: rdata_r <= cnt_r;
                default: rdata_r <= READ_NONE;
            endcase
        end
    end

    assign reg_rdata = rdata_r;

    // ********************************************************************
    // Checks
    // ********************************************************************
    chk_clear_match: assert property (@(posedge clk) disable iff (!rst_n)
        count_enable_r && !is_pwm && tick && match && !wr_mode
        |=> cnt_r == COUNT_RST && irq_r)
        else $error("Match did not clear counter with interrupt.");

    chk_count_step: assert property (@(posedge clk) disable iff (!rst_n)
        count_enable_r && tick && !match && !wr_mode
        |=> cnt_r == 8'($past(cnt_r) + 8'h01))
        else $error("Counter did not step by one.");

    chk_stop_clears: assert property (@(posedge clk) disable iff (!rst_n)
        !count_enable_r |=> cnt_r == COUNT_RST)
        else $error("Stopped counter not at zero.");

    chk_square_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        count_enable_r && !is_pwm && active_level_r && tick && match
        && !wr_mode |=> ff_r != $past(ff_r))
        else $error("Output flop missed a toggle.");

    chk_out_disable: assert property (@(posedge clk) disable iff (!rst_n)
        !output_enable_r |=> !timer_output)
        else $error("Disabled output not low.");

    chk_pwm_stopped: assert property (@(posedge clk) disable iff (!rst_n)
        is_pwm && !count_enable_r && output_enable_r && !wr_mode
        ##1 !wr_mode |=> timer_output == active_level_r)
        else $error("Stopped PWM output not inactive.");

    chk_pwm_buffer: assert property (@(posedge clk) disable iff (!rst_n)
        is_pwm && count_enable_r && !(tick && cnt_r == COUNT_TOP)
        |=> cmp_act_r == $past(cmp_act_r))
        else $error("PWM compare changed away from overflow.");

    chk_pwm_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        is_pwm && count_enable_r && tick && cnt_r == COUNT_TOP && !wr_mode
        |=> cnt_r == COUNT_RST
        && pwm_act_r == (cmp_act_r != COUNT_RST))
        else $error("PWM wrap or active start wrong.");

endmodule

/* File: sim/tmev_pin_model.sv */
`timescale 1ns/1ps
// ****
// Pin load and external pulse source
// ****
module tmev_pin_model (
    input wire logic clk,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic src_drive,
    input wire logic src_lvl,
    output logic pin
);
    logic last_r;
    // A floating wire flips each cycle, so a stale level never counts.
    always_ff @(posedge clk) begin
        last_r <= ~pin;
    end
    always_comb begin
        if (pin_oe) begin
            pin = pin_out;
        end else if (src_drive) begin
            pin = src_lvl;
        end else begin
            pin = last_r;
        end
    end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import tmev_pkg::*;
    logic clk, rst_n, reg_wr, reg_rd, port_latch, src_drive, src_lvl;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic pin, pin_out, pin_oe, tout, irq;
    int bad_count, checks, seed, n, m, w, d;
    int sel_tab[4] = '{2, 2, 3, 4};
    int div_tab[4] = '{1, 1, 2, 16};
    logic [7:0] sq_tab[2] = '{8'h0B, 8'h07};

    tmev_counter_top #(.PIN_SEL(0)) tmev_counter_top_inst (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .port_latch(port_latch), .pin_in(pin), .pin_out(pin_out),
        .pin_oe(pin_oe), .timer_output(tout),
        .match_interrupt_request(irq)
    );
    tmev_pin_model tmev_pin_model_inst (
        .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .src_drive(src_drive), .src_lvl(src_lvl), .pin(pin)
    );

    // ****
    // Clock, checking and bus tasks
    // ****
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    task automatic give_verdict();
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] g, e, input string s);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic cmp1(input logic g, e, input string s);
        cmp8({7'h00, g}, {7'h00, e}, s);
    endtask
    task automatic cmpn(input int g, e, input string s);
        checks++;
        if (g != e) begin
            bad_count++;
            $display("[ERR] %0t %s got %0d exp %0d", $time, s, g, e);
        end
    endtask
    function automatic int rnd(input int k);
        return $unsigned($random(seed)) % k;
    endfunction
    // Inputs change 2 ns after the rising edge, never on it.
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1;
        step(1);
        reg_wr = 0;
        step(1);
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1;
        step(1);
        reg_rd = 0;
        step(1);
        cmp8(reg_rdata, e, "read");
    endtask
    task automatic wait_irq(output int c);
        c = 0;
        do begin
            step(1);
            c++;
        end while (irq !== 1'b1 && c < 5000);
    endtask
    task automatic wait_tout(input logic v, output int c);
        c = 0;
        do begin
            step(1);
            c++;
        end while (tout !== v && c < 5000);
    endtask
    task automatic count_high(input int k, output int c);
        c = 0;
        repeat (k) begin
            step(1);
            if (tout !== 1'b0) c++;
        end
    endtask
    task automatic ext_lvl(input logic v);
        src_lvl = v;
        step(8);
    endtask

    // ****
    // Scenarios
    // ****
    initial begin
        seed = 57;
        bad_count = 0;
        checks = 0;
        rst_n = 0;
        reg_wr = 0;
        reg_rd = 0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        port_latch = 0;
        src_drive = 1;
        src_lvl = 0;
        repeat (10) @(posedge clk);
        #2;
        rst_n = 1;
        cmp1(pin_oe, 1'b0, "oe reset");
        rchk(OFS_PORT1_DIR, PORT_DIR_RST);
        rchk(OFS_PORT3_DIR, PORT_DIR_RST);
        rchk(OFS_MODE, 8'h00);
        rchk(16'hFF30, READ_NONE);
        rv = 8'($random(seed));
        wr(OFS_PORT1_DIR, rv);
        rchk(OFS_PORT1_DIR, rv);
        cmp1(pin_oe, ~rv[7], "oe dir");
        wr(OFS_PORT3_DIR, 8'h00);
        rchk(OFS_PORT3_DIR, PORT3_FIXED);
        wr(OFS_PORT1_DIR, PORT_DIR_RST);
        for (int i = 0; i < 4; i++) begin
            n = (i == 0) ? 0 : (i == 1) ? 255 : 1 + rnd(12);
            wr(OFS_CLKSEL, 8'(sel_tab[i]));
            wr(OFS_CMP, 8'(n));
            wr(OFS_MODE, 8'h80);
            wait_irq(w);
            wait_irq(w);
            cmpn(w, div_tab[i] * (n + 1), "interval");
            wait_irq(w);
            cmpn(w, div_tab[i] * (n + 1), "repeat");
            wr(OFS_MODE, 8'h00);
            rchk(OFS_COUNT, COUNT_RST);
        end
        port_latch = 1'($random(seed));
        wr(OFS_CLKSEL, 8'h01);
        wr(OFS_CMP, 8'h02);
        wr(OFS_MODE, 8'h00);
        wr(OFS_MODE, 8'h80);
        ext_lvl(1);
        rchk(OFS_COUNT, 8'h01);
        ext_lvl(0);
        rchk(OFS_COUNT, 8'h01);
        ext_lvl(1);
        ext_lvl(0);
        src_lvl = 1;
        wait_irq(w);
        cmpn(int'(w < 10), 1, "event match");
        rchk(OFS_COUNT, 8'h00);
        wr(OFS_MODE, 8'h00);
        wr(OFS_CLKSEL, 8'h00);
        wr(OFS_MODE, 8'h80);
        ext_lvl(0);
        rchk(OFS_COUNT, 8'h01);
        ext_lvl(1);
        rchk(OFS_COUNT, 8'h01);
        wr(OFS_MODE, 8'h00);
        port_latch = 0;
        wr(OFS_PORT1_DIR, 8'h7F);
        wr(OFS_CLKSEL, 8'h02);
        for (int i = 0; i < 2; i++) begin
            n = rnd(20);
            wr(OFS_CMP, 8'(n));
            wr(OFS_MODE, sq_tab[i]);
            cmp1(tout, sq_tab[i][3], "preset");
            cmp1(pin_out, sq_tab[i][3], "pin");
            wr(OFS_MODE, 8'h83);
            wait_tout(~sq_tab[i][3], w);
            wait_tout(sq_tab[i][3], w);
            cmpn(w, n + 1, "half wave");
            wr(OFS_MODE, 8'h03);
        end
        wr(OFS_MODE, 8'h08);
        cmp1(tout, 1'b0, "oe off");
        n = 100 + rnd(150);
        m = 1 + rnd(60);
        wr(OFS_CMP, 8'(n));
        wr(OFS_MODE, 8'h41);
        wr(OFS_MODE, 8'hC1);
        count_high(200, w);
        cmpn(w, 0, "before wrap");
        wait_tout(1, w);
        wr(OFS_CMP, 8'(m));
        wait_tout(0, w);
        cmpn(w + 2, n, "old width");
        wait_tout(1, w);
        cmpn(w, 256 - n, "gap");
        wait_tout(0, w);
        cmpn(w, m, "new width");
        // Stop inside the active phase, else the forced level is not seen.
        wait_tout(1, w);
        wr(OFS_MODE, 8'h41);
        step(1);
        cmp1(tout, 1'b0, "stop");
        wr(OFS_MODE, 8'h43);
        cmp1(tout, 1'b1, "idle low act");
        wr(OFS_MODE, 8'hC3);
        wait_tout(0, w);
        wait_tout(1, w);
        cmpn(w, m, "low width");
        wait_tout(0, w);
        wr(OFS_MODE, 8'h43);
        step(1);
        cmp1(tout, 1'b1, "stop low act");
        wr(OFS_MODE, 8'h40);
        wr(OFS_MODE, 8'hC0);
        count_high(600, w);
        cmpn(w, 0, "pwm oe off");
        wr(OFS_MODE, 8'h00);
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end
endmodule
